// File: gpio_irq_pkg.sv
`default_nettype none
package gpio_irq_pkg;
    localparam int          PINS        = 16;
    localparam int          HALF        = 8;
    localparam int          DW          = 32;
    // Register indices; the byte address on APB is four times the index.
    localparam logic [31:0] IDX_EN      = 32'h1500_1084;
    localparam logic [31:0] IDX_PEND    = 32'h1500_1086;
    localparam logic [31:0] IDX_TRIG    = 32'h1500_1088;
    localparam logic [31:0] IDX_LVL_LO  = 32'h1500_108a;
    localparam logic [31:0] IDX_LVL_HI  = 32'h1500_108c;
    localparam logic [31:0] IDX_EVT     = 32'h1500_1090;
    localparam logic [31:0] IDX_MASK    = 32'h1500_1092;
    localparam logic [31:0] ADDR_EN     = IDX_EN << 2;
    localparam logic [31:0] ADDR_PEND   = IDX_PEND << 2;
    localparam logic [31:0] ADDR_TRIG   = IDX_TRIG << 2;
    localparam logic [31:0] ADDR_LVL_LO = IDX_LVL_LO << 2;
    localparam logic [31:0] ADDR_LVL_HI = IDX_LVL_HI << 2;
    localparam logic [31:0] ADDR_EVT    = IDX_EVT << 2;
    localparam logic [31:0] ADDR_MASK   = IDX_MASK << 2;
    // Level register layout: both-edge enables above, polarity below.
    localparam int          BOTH_LSB    = 8;
    localparam int          POL_LSB     = 0;
    localparam logic [15:0] RST_REG16   = 16'h0000;
    localparam logic [31:0] RST_RDATA   = 32'h0000_0000;
    typedef enum logic {ST_IDLE, ST_ACCESS} apb_state_t;
endpackage
`default_nettype wire

// File: gpio_pin_interrupt_detect.sv
// Function
// R01: One detection-enable bit per pin 15:0; 1 enables, 0 disables detection.
// R02: Enabled pin meeting its selected trigger condition sets its pending flag.
// R03: A disabled pin never sets its pending flag.
// R04: Pending register reads 1 for pins with an interrupt, 0 otherwise.
// R05: Software clears a flag by writing 1, then writes 0 to cancel.
// R06: Software clear works only on edge-mode pins; level-mode clears ignored.
// R07: Level-mode pending flag clears itself once the source goes inactive.
// R08: One trigger-select bit per pin; 1 edge, 0 level.
// R09: Edge mode detects pin transitions, per both-edge and polarity settings.
// R10: Level mode detects while the pin sits at its polarity level.
// R11: Both-edge enables for pins 7:0 sit in bits 15:8 of low level register.
// R12: Polarity for pins 7:0 in bits 7:0; high/rising is 1, low/falling 0.
// R13: Both-edge enable applies only in edge mode.
// R14: Both-edge enable set ignores polarity and detects rising and falling edges.
// R15: Detected requests reach the host through one interrupt request output; irq here is raised only for new events in evt_reg whose mask_reg bit is set.
// R16: A second level register holds both-edge and polarity bits for pins 15:8.
// R17: Pin inputs are synchronised before edge or level evaluation.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_interrupt_detect (
    input  wire logic                           sys_clk,
    input  wire logic                           arst_n,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [31:0]                    paddr,
    input  wire logic [gpio_irq_pkg::DW-1:0]    pwdata,
    input  wire logic [3:0]                     pstrb,
    output var  logic [gpio_irq_pkg::DW-1:0]    prdata,
    output var  logic                           pready,
    output var  logic                           pslverr,
    input  wire logic [gpio_irq_pkg::PINS-1:0]  gpio_in,
    output var  logic                           irq
);
    import gpio_irq_pkg::*;

    logic [15:0] en_reg;
    logic [15:0] trig_reg;
    logic [15:0] lvl_lo_reg;
    logic [15:0] lvl_hi_reg;
    logic [15:0] pend_reg;
    logic [15:0] clr_hold_reg;
    logic [15:0] evt_reg;
    logic [15:0] mask_reg;
    logic [15:0] sync1_reg;
    logic [15:0] sync2_reg;
    logic [15:0] prev_reg;
    logic [15:0] hit;
    logic [15:0] pend_next;
    logic [15:0] rd_clr_reg;
    logic [31:0] rdata_next;
    logic        err_next;
    logic        sel_evt_reg;
    logic        wr_go;
    logic        rd_go;
    apb_state_t  state_reg;

    // Two flops before any use; a third keeps the previous level for edges.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= RST_REG16;
            sync2_reg <= RST_REG16;
            prev_reg  <= RST_REG16;
        end else begin
            sync1_reg <= gpio_in;   // R17
            sync2_reg <= sync1_reg; // R17
            prev_reg  <= sync2_reg;
        end
    end

    // Per-pin trigger evaluation.
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            logic [15:0] lvl;
            logic        both;
            logic        pol;
            logic        s;
            logic        p;
            logic        edge_hit;
            logic        level_hit;
            if (g < HALF) begin : g_lo
                assign lvl = lvl_lo_reg;             // R11 R12
            end else begin : g_hi
                assign lvl = lvl_hi_reg;             // R16
            end
            assign both      = lvl[BOTH_LSB + (g % HALF)];
            assign pol       = lvl[POL_LSB + (g % HALF)];
            assign s         = sync2_reg[g];
            assign p         = prev_reg[g];
            assign edge_hit  = both ? (s ^ p) :      // R14
                               (pol ? (s & ~p) : (~s & p)); // R09 R12
            assign level_hit = (s == pol);           // R10
            // The both-edge bit only enters through edge_hit.
            assign hit[g] = en_reg[g] &              // R01 R03
                            (trig_reg[g] ? edge_hit : level_hit); // R08 R13 R02
        end
    endgenerate

    // A new detection wins over a pending clear in the same cycle.
    always_comb begin
        pend_next = hit | (pend_reg & trig_reg & ~clr_hold_reg); // R02 R06
        pend_next = pend_next | (hit & ~trig_reg);               // R07
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_reg <= RST_REG16;
        end else begin
            pend_reg <= pend_next;
        end
    end

    // APB: setup latches the answer, access completes with pready high.
    assign wr_go = psel && penable && pready && pwrite;
    assign rd_go = psel && penable && pready && !pwrite;

    always_comb begin
        rdata_next = RST_RDATA;
        err_next   = 1'b0;
        if (paddr == ADDR_EN) begin
            rdata_next[15:0] = en_reg;
        end else if (paddr == ADDR_PEND) begin
            rdata_next[15:0] = pend_reg; // R04
        end else if (paddr == ADDR_TRIG) begin
            rdata_next[15:0] = trig_reg;
        end else if (paddr == ADDR_LVL_LO) begin
            rdata_next[15:0] = lvl_lo_reg;
        end else if (paddr == ADDR_LVL_HI) begin
            rdata_next[15:0] = lvl_hi_reg;
        end else if (paddr == ADDR_EVT) begin
            rdata_next[15:0] = evt_reg;
        end else if (paddr == ADDR_MASK) begin
            rdata_next[15:0] = mask_reg;
        end else begin
            err_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg   <= ST_IDLE;
            pready      <= 1'b0;
            prdata      <= RST_RDATA;
            pslverr     <= 1'b0;
            rd_clr_reg  <= RST_REG16;
            sel_evt_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (psel && !penable) begin
                        state_reg   <= ST_ACCESS;
                        pready      <= 1'b1;
                        prdata      <= pwrite ? RST_RDATA : rdata_next;
                        pslverr     <= err_next;
                        rd_clr_reg  <= rdata_next[15:0];
                        sel_evt_reg <= (paddr == ADDR_EVT) && !pwrite;
                    end
                end
                default: begin
                    state_reg   <= ST_IDLE;
                    pready      <= 1'b0;
                    pslverr     <= 1'b0;
                    sel_evt_reg <= 1'b0;
                end
            endcase
        end
    end

    // Writes need both low byte lanes; upper lanes hold only reserved bits.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            en_reg       <= RST_REG16;
            trig_reg     <= RST_REG16;
            lvl_lo_reg   <= RST_REG16;
            lvl_hi_reg   <= RST_REG16;
            clr_hold_reg <= RST_REG16;
            mask_reg     <= RST_REG16;
        end else if (wr_go && !pslverr && (pstrb[1:0] == 2'h3)) begin
            if (paddr == ADDR_EN) begin
                en_reg <= pwdata[15:0];       // R01
            end else if (paddr == ADDR_PEND) begin
                clr_hold_reg <= pwdata[15:0]; // R05 R06
            end else if (paddr == ADDR_TRIG) begin
                trig_reg <= pwdata[15:0];     // R08
            end else if (paddr == ADDR_LVL_LO) begin
                lvl_lo_reg <= pwdata[15:0];   // R11 R12
            end else if (paddr == ADDR_LVL_HI) begin
                lvl_hi_reg <= pwdata[15:0];   // R16
            end else if (paddr == ADDR_MASK) begin
                mask_reg <= pwdata[15:0];
            end
        end
    end

    // Only bits the read actually returned are cleared, so a newer event stays.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            evt_reg <= RST_REG16;
        end else if (rd_go && sel_evt_reg) begin
            evt_reg <= (evt_reg & ~rd_clr_reg) | (hit & ~pend_reg);
        end else begin
            evt_reg <= evt_reg | (hit & ~pend_reg);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_reg & mask_reg); // R15
        end
    end

    // Checking helpers.
    logic [15:0] keep_v;
    logic [15:0] lvl_v;
    logic        cfg_rise0;
    logic        cfg_both0;
    logic        cfg_high1;
    logic        cfg_fall0;
    logic [15:0] pol_v;
    logic [15:0] both_v;
    logic [15:0] rise_v;
    logic [15:0] fall_v;
    logic [15:0] edge_v;
    logic [15:0] lvl_en_v;
    assign keep_v    = pend_reg & trig_reg & ~clr_hold_reg;
    assign lvl_v     = ~trig_reg;
    assign cfg_rise0 = en_reg[0] && trig_reg[0] && lvl_lo_reg[0] && !lvl_lo_reg[8];
    assign cfg_both0 = en_reg[0] && trig_reg[0] && lvl_lo_reg[8];
    assign cfg_high1 = en_reg[1] && !trig_reg[1] && lvl_lo_reg[1];
    assign cfg_fall0 = en_reg[0] && trig_reg[0] && !lvl_lo_reg[0] && !lvl_lo_reg[8];
    // Reference terms are rebuilt from the registers, not taken from the per-pin logic.
    assign pol_v     = {lvl_hi_reg[POL_LSB +: HALF], lvl_lo_reg[POL_LSB +: HALF]};
    assign both_v    = {lvl_hi_reg[BOTH_LSB +: HALF], lvl_lo_reg[BOTH_LSB +: HALF]};
    assign rise_v    = sync2_reg & ~prev_reg;
    assign fall_v    = ~sync2_reg & prev_reg;
    assign edge_v    = en_reg & trig_reg & ((both_v & (rise_v | fall_v)) |
                       (~both_v & pol_v & rise_v) | (~both_v & ~pol_v & fall_v));
    assign lvl_en_v  = en_reg & ~trig_reg;

    sequence s_rise0;
        (!gpio_in[0] ##1 gpio_in[0]) ##0 cfg_rise0 [*3];
    endsequence
    sequence s_fall0;
        (gpio_in[0] ##1 !gpio_in[0]) ##0 cfg_both0 [*3];
    endsequence
    sequence s_high1;
        (gpio_in[1] && cfg_high1) [*3];
    endsequence
    sequence s_fall_pol0;
        (gpio_in[0] ##1 !gpio_in[0]) ##0 cfg_fall0 [*3];
    endsequence

    property p_r01;
        @(posedge sys_clk) disable iff (!arst_n)
        (wr_go && paddr == ADDR_EN && pstrb[1:0] == 2'h3) |=> (en_reg == $past(pwdata[15:0]));
    endproperty
    a_r01: assert property (p_r01) else $error("enable write lost"); // R01

    property p_r03;
        @(posedge sys_clk) disable iff (!arst_n)
        1'b1 |=> ((pend_reg & ~$past(pend_reg) & ~$past(en_reg)) == 16'h0000);
    endproperty
    a_r03: assert property (p_r03) else $error("disabled pin set pending"); // R03

    property p_r04;
        @(posedge sys_clk) disable iff (!arst_n)
        (psel && !penable && !pwrite && paddr == ADDR_PEND) |=> (prdata[15:0] == $past(pend_reg));
    endproperty
    a_r04: assert property (p_r04) else $error("pending read wrong"); // R04

    property p_r06;
        @(posedge sys_clk) disable iff (!arst_n)
        1'b1 |=> (($past(keep_v) & ~pend_reg) == 16'h0000);
    endproperty
    a_r06: assert property (p_r06) else $error("edge flag lost without clear"); // R06

    property p_r07;
        @(posedge sys_clk) disable iff (!arst_n)
        1'b1 |=> ((pend_reg & $past(lvl_v)) == ($past(hit) & $past(lvl_v)));
    endproperty
    a_r07: assert property (p_r07) else $error("level flag not following source"); // R07

    property p_r09;
        @(posedge sys_clk) disable iff (!arst_n)
        s_rise0 |=> pend_reg[0];
    endproperty
    a_r09: assert property (p_r09) else $error("rising edge missed"); // R09

    property p_r14;
        @(posedge sys_clk) disable iff (!arst_n)
        s_fall0 |=> pend_reg[0];
    endproperty
    a_r14: assert property (p_r14) else $error("both-edge fall missed"); // R14

    property p_r10;
        @(posedge sys_clk) disable iff (!arst_n)
        s_high1 |=> pend_reg[1];
    endproperty
    a_r10: assert property (p_r10) else $error("high level missed"); // R10

    property p_r15;
        @(posedge sys_clk) disable iff (!arst_n)
        ((evt_reg & mask_reg) != 16'h0000) |=> irq;
    endproperty
    a_r15: assert property (p_r15) else $error("irq not raised"); // R15

    property p_r12;
        @(posedge sys_clk) disable iff (!arst_n)
        s_fall_pol0 |=> pend_reg[0];
    endproperty
    a_r12: assert property (p_r12) else $error("falling edge missed"); // R12

    property p_r10_all;
        @(posedge sys_clk) disable iff (!arst_n)
        1'b1 |=> ((pend_reg & $past(lvl_en_v)) ==
                  (~($past(sync2_reg) ^ $past(pol_v)) & $past(lvl_en_v)));
    endproperty
    a_r10_all: assert property (p_r10_all) else $error("level flag wrong"); // R10 R16

    property p_r09_all;
        @(posedge sys_clk) disable iff (!arst_n)
        1'b1 |=> (($past(edge_v) & ~pend_reg) == 16'h0000);
    endproperty
    a_r09_all: assert property (p_r09_all) else $error("selected edge missed"); // R09 R14

    property p_r13;
        @(posedge sys_clk) disable iff (!arst_n)
        1'b1 |=> ((pend_reg & ~$past(pend_reg) & $past(trig_reg) & ~$past(edge_v)) == 16'h0000);
    endproperty
    a_r13: assert property (p_r13) else $error("edge flag set without its edge"); // R13

    property p_r06_clr;
        @(posedge sys_clk) disable iff (!arst_n)
        1'b1 |=> (($past(pend_reg & trig_reg & clr_hold_reg & ~hit) & pend_reg) == 16'h0000);
    endproperty
    a_r06_clr: assert property (p_r06_clr) else $error("edge flag not cleared"); // R06

    property p_r15_low;
        @(posedge sys_clk) disable iff (!arst_n)
        ((evt_reg & mask_reg) == 16'h0000) |=> !irq;
    endproperty
    a_r15_low: assert property (p_r15_low) else $error("irq raised while quiet"); // R15

    property p_r15_evt;
        @(posedge sys_clk) disable iff (!arst_n)
        1'b1 |=> ((evt_reg & $past(hit & ~pend_reg)) == $past(hit & ~pend_reg));
    endproperty
    a_r15_evt: assert property (p_r15_evt) else $error("event not recorded"); // R15

    property p_r01_strb;
        @(posedge sys_clk) disable iff (!arst_n)
        (wr_go && paddr == ADDR_EN && pstrb[1:0] != 2'h3) |=> $stable(en_reg);
    endproperty
    a_r01_strb: assert property (p_r01_strb) else $error("partial write changed enable"); // R01

    property p_r08;
        @(posedge sys_clk) disable iff (!arst_n)
        (wr_go && paddr == ADDR_TRIG && pstrb[1:0] == 2'h3) |=>
            (trig_reg == $past(pwdata[15:0]));
    endproperty
    a_r08: assert property (p_r08) else $error("trigger write lost"); // R08

    property p_r11;
        @(posedge sys_clk) disable iff (!arst_n)
        (wr_go && paddr == ADDR_LVL_LO && pstrb[1:0] == 2'h3) |=>
            (lvl_lo_reg == $past(pwdata[15:0]));
    endproperty
    a_r11: assert property (p_r11) else $error("low level register write lost"); // R11

    property p_r16;
        @(posedge sys_clk) disable iff (!arst_n)
        (wr_go && paddr == ADDR_LVL_HI && pstrb[1:0] == 2'h3) |=>
            (lvl_hi_reg == $past(pwdata[15:0]));
    endproperty
    a_r16: assert property (p_r16) else $error("high level register write lost"); // R16
endmodule
`default_nettype wire

// File: gpio_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// Pins move right after the rising edge, by non-blocking assignment, like any other input.
module pin_source (
    input  wire logic        sys_clk,
    input  wire logic [15:0] want,
    output var  logic [15:0] gpio_in
);
    always @(posedge sys_clk) begin
        gpio_in <= want;
    end
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import gpio_irq_pkg::*;
    logic        sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, rerr;
    logic [31:0] paddr, pwdata, prdata, rdat;
    logic [3:0]  pstrb;
    logic [15:0] gpio_in, want, en_m, trg_m, lo_m, hi_m, pend_m, hold_m, evt_m, mask_m, pin_m;
    int          n_errors, cmp_count, cycles;
    logic [31:0] regs [5] = '{ADDR_EN, ADDR_TRIG, ADDR_LVL_LO, ADDR_LVL_HI, ADDR_MASK};

    gpio_pin_interrupt_detect dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpio_in(gpio_in), .irq(irq));
    pin_source pins_u (.sys_clk(sys_clk), .want(want), .gpio_in(gpio_in));

    always #4 sys_clk = ~sys_clk;

    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // A hang counts as a mismatch and closes the run.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] st);
        @(posedge sys_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= st; penable <= 1'b0;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Ends when pready is seen high; a hang is left to the bench timeout.
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // Reference detector: level flags follow the pins, edge flags stick until held clear.
    function automatic void recalc(input logic [15:0] np);
        logic [15:0] old;
        logic        pol, both, hit;
        old = pend_m;
        for (int i = 0; i < 16; i++) begin
            pol  = i < 8 ? lo_m[i % 8] : hi_m[i % 8];
            both = i < 8 ? lo_m[i % 8 + 8] : hi_m[i % 8 + 8];
            if (trg_m[i]) begin
                hit = both ? (np[i] ^ pin_m[i]) : (pol ? (np[i] & !pin_m[i]) : (!np[i] & pin_m[i]));
                pend_m[i] = (pend_m[i] & !hold_m[i]) | (en_m[i] & hit);
            end else begin
                pend_m[i] = en_m[i] & (np[i] == pol);
            end
        end
        evt_m |= pend_m & ~old;
        pin_m = np;
    endfunction

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0000, d}, 4'hf);
        case (a)
            ADDR_EN:     en_m = d;
            ADDR_TRIG:   trg_m = d;
            ADDR_LVL_LO: lo_m = d;
            ADDR_LVL_HI: hi_m = d;
            ADDR_MASK:   mask_m = d;
            ADDR_PEND:   hold_m = d;
            default: ;
        endcase
        recalc(pin_m);
    endtask

    task automatic rd(input logic [31:0] a);
        logic [15:0] e;
        case (a)
            ADDR_EN:     e = en_m;
            ADDR_TRIG:   e = trg_m;
            ADDR_LVL_LO: e = lo_m;
            ADDR_LVL_HI: e = hi_m;
            ADDR_MASK:   e = mask_m;
            ADDR_PEND:   e = pend_m;
            ADDR_EVT:    e = evt_m;
            default:     e = 16'h0000;
        endcase
        apb(1'b0, a, 32'h0000_0000, 4'hf);
        chk(rdat, {16'h0000, e}, "read data");
        chk(rerr, !(a inside {regs, ADDR_PEND, ADDR_EVT}), "slave error");
        if (a == ADDR_EVT) evt_m = 16'h0000;
    endtask

    task automatic chk_irq();
        repeat (2) @(negedge sys_clk);
        chk(irq, |(evt_m & mask_m), "irq level");
    endtask

    initial begin
        sys_clk = 0; arst_n = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; pstrb = 4'hf; want = 0;
        {en_m, trg_m, lo_m, hi_m, pend_m, hold_m, evt_m, mask_m, pin_m} = '0;
        n_errors = 0; cmp_count = 0; cycles = 0;
        void'($urandom(67));
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        foreach (regs[k]) rd(regs[k]);
        rd(ADDR_PEND);
        rd(ADDR_EVT);
        rd(32'h0000_0100);
        $display("reset values done");
        foreach (regs[k]) begin
            wr(regs[k], 16'($urandom));
            rd(regs[k]);
        end
        apb(1'b1, ADDR_EN, ~{16'h0000, en_m}, 4'h1);
        rd(ADDR_EN);
        $display("register access done");
        // Each phase quiets detection before changing modes, so no pending flag is carried across.
        for (int ph = 0; ph < 4; ph++) begin
            wr(ADDR_EN, 16'h0000);
            wr(ADDR_PEND, 16'hffff);
            wr(ADDR_PEND, 16'h0000);
            foreach (regs[k]) wr(regs[k], 16'($urandom));
            // Early phases pin down pin 0 as an edge pin and pin 1 as a level pin.
            if (ph < 3) begin
                wr(ADDR_EN, en_m | 16'h0003);
                wr(ADDR_TRIG, (trg_m | 16'h0001) & 16'hfffd);
                wr(ADDR_LVL_LO, ph == 0 ? 16'h0003 : (ph == 1 ? 16'h0103 : 16'h0000));
            end
            for (int it = 0; it < 10; it++) begin
                @(posedge sys_clk);
                want <= 16'($urandom);
                @(posedge sys_clk);
                recalc(want);
                repeat (8) @(posedge sys_clk);
                rd(ADDR_PEND);
                chk_irq();
                if (it % 3 == 0) begin
                    wr(ADDR_PEND, 16'($urandom));
                    rd(ADDR_PEND);
                    wr(ADDR_PEND, 16'h0000);
                end
                if (it % 4 == 1) begin
                    rd(ADDR_EVT);
                    chk_irq();
                end
            end
            $display("detection phase %0d done", ph);
        end
        test_done();
    end
endmodule
`default_nettype wire
